/* File: rtl/dspreg_pkg.sv */
/*
 * Constants for the register set of the 16-bit fixed-point signal processor core:
 * register select codes, status bit positions, field widths and reset values.
 * Assumes it is compiled before every file that names it.
 */
package dspreg_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned WIDE_W = 24;
    localparam int unsigned PTR_W = 8;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned NUM_PTR = 6;
    localparam int unsigned NUM_CHAN = 2;

    // Register select codes on the core's source and destination fields.
    localparam logic [4:0] SEL_MPY_X = 5'h00;
    localparam logic [4:0] SEL_MPY_Y = 5'h01;
    localparam logic [4:0] SEL_ACC = 5'h02;
    localparam logic [4:0] SEL_STATUS = 5'h03;
    localparam logic [4:0] SEL_PRODUCT = 5'h04;
    localparam logic [4:0] SEL_PC = 5'h05;
    localparam logic [4:0] SEL_DBUS = 5'h06;
    localparam logic [4:0] SEL_PTR_BASE = 5'h08;
    localparam logic [1:0] GRP_EXT = 2'h2;
    localparam logic [1:0] GRP_DPTR = 2'h3;

    // External register numbers taken by the on-chip peripherals.
    localparam logic [2:0] EXT_TIMER = 3'h4;
    localparam logic [2:0] EXT_CHAN0 = 3'h5;
    localparam logic [2:0] EXT_CHAN1 = 3'h6;
    localparam logic [2:0] EXT_CONFIG = 3'h7;

    // Status register bit positions.
    localparam int unsigned SR_NEG = 15;
    localparam int unsigned SR_OVF = 14;
    localparam int unsigned SR_ZERO = 13;
    localparam int unsigned SR_CARRY = 12;
    localparam int unsigned SR_UIN1 = 11;
    localparam int unsigned SR_UIN0 = 10;
    localparam int unsigned SR_SHIFT3 = 9;
    localparam int unsigned SR_SAT = 8;
    localparam int unsigned SR_IRQ_ALLOW = 7;
    localparam int unsigned SR_UOUT1 = 6;
    localparam int unsigned SR_UOUT0 = 5;
    localparam int unsigned SR_SFD_HI = 4;
    localparam int unsigned SR_SFD_LO = 3;
    localparam int unsigned SR_LOOP_HI = 2;
    localparam int unsigned SR_LOOP_LO = 0;
    localparam logic [15:0] SR_SW_MASK = 16'h03FF;
    localparam logic [15:0] SR_RESET = 16'h0000;

    // Enable bits inside the peripheral configuration words.
    localparam int unsigned TIMER_EN_BIT = 15;
    localparam int unsigned CHAN0_EN_BIT = 15;
    localparam int unsigned CHAN1_EN_BIT = 15;
    localparam logic [15:0] TIMER_CFG_RESET = 16'h8000;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    localparam logic [23:0] ACC_SAT_POS = 24'h7FFFFF;
    localparam logic [23:0] ACC_SAT_NEG = 24'h800000;
    localparam logic [7:0] ACC_LOW_ZERO = 8'h00;
    localparam int unsigned PROD_SHIFT = 3;
    localparam int unsigned PROD_LSB = 8;

    typedef enum logic [0:0] {
        DSPREG_CFG_FIRST = 1'b0,
        DSPREG_CFG_SECOND = 1'b1
    } dspreg_cfg_slot_t;
endpackage

/* File: rtl/dspreg_core.sv */
/*
 * Programmer-visible register set of the signal processor core.
 * Assumes the instruction sequencer presents one read select and one write select per
 * cycle, all inputs synchronous to core_clk_i, and data RAM and the external bus pins
 * handled outside, driven from the strobes this block makes.
 */
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Product register is readable but writes addressed to it are ignored.
// - A 16-bit move into accumulator fills upper bits, clears low byte.
// - Accumulator as a transfer source gives only its upper 16 bits.
// - Six 8-bit RAM pointers, three per bank, read and written directly.
// - Eight 16-bit external register addresses are decoded onto the outside bus.
// - With serial channels and timer enabled, only four external addresses stay free.
// - Internal bus register reads back the current internal data bus, read-only.
// - Data pointer picks word: status bits S4-S3 give group, operand bits offset.
// - Writing a data pointer writes that data RAM word.
// - Each ALU operation updates negative, overflow, zero and carry flags.
// - Status bits S11 and S10 follow the two user input pins.
// - Status fully readable; software writes reach only bits S9-S0.
// - Loop-size field sets pointer modulo: 000 is 256, else two to the n.
// - With S8 set, overflowing ALU results clamp to the extreme values.
// - With S9 and the shift option, product shifts right arithmetically by three.
// - User output pins drive the inverse of status bits S6 and S5.
// - Writing the program counter inserts one no-operation cycle.
// - Disabling a peripheral hands its external address back to outside devices.
// - Enabled peripheral addresses still show bus strobes and drive write data out; reads ignore the pins.
// - Received word lands in second buffer; writing it moves word to first.
// - Word written to second buffer is sent out; both channels run alike.
// - Configuration address takes paired writes: serial first, wait-state second.
// - Interrupt lines: zero general, one serial channels, two timer.
// - Every reset clears the status register; warm reset keeps other registers.
module dspreg_core (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic warm_reset_i,
    input wire logic rd_en_i,
    input wire logic [4:0] rd_sel_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic wr_en_i,
    input wire logic [4:0] wr_sel_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [15:0] dbus_i,
    input wire logic alu_valid_i,
    input wire logic [24:0] alu_sum_i,
    input wire logic alu_carry_i,
    input wire logic mpy_valid_i,
    input wire logic mpy_shift_i,
    input wire logic pc_advance_i,
    input wire logic [15:0] pc_next_i,
    output logic [15:0] pc_o,
    output logic nop_insert_o,
    input wire logic [5:0] ptr_step_i,
    output logic [47:0] ram_ptr_o,
    output logic [23:0] acc_o,
    output logic [23:0] product_o,
    output logic [15:0] mpy_x_o,
    output logic [15:0] mpy_y_o,
    output logic [15:0] status_o,
    output logic dptr_bank_o,
    output logic [3:0] dptr_addr_o,
    input wire logic [15:0] dptr_rdata_i,
    output logic dptr_wr_o,
    output logic [15:0] dptr_wdata_o,
    output logic [2:0] ext_addr_o,
    output logic ext_rd_o,
    output logic ext_wr_o,
    output logic [15:0] ext_dout_o,
    output logic ext_dout_oe_o,
    input wire logic [15:0] ext_din_i,
    output logic [7:0] ext_internal_o,
    input wire logic [31:0] chan_rx_data_i,
    input wire logic [1:0] chan_rx_valid_i,
    output logic [31:0] chan_tx_data_o,
    output logic [1:0] chan_tx_load_o,
    output logic [15:0] serial_config_o,
    output logic [15:0] waitstate_config_o,
    output logic [15:0] timer_config_o,
    input wire logic [2:0] irq_pin_i,
    input wire logic chan_done_i,
    input wire logic timer_zero_i,
    output logic irq_line_general_o,
    output logic irq_line_serial_o,
    output logic irq_line_timer_o,
    output logic irq_allow_o,
    input wire logic irq_entry_i,
    input wire logic user_in_zero_i,
    input wire logic user_in_one_i,
    output logic user_out_zero_o,
    output logic user_out_one_o
);
    logic [15:0] mpy_x_reg;
    logic [15:0] mpy_y_reg;
    logic [23:0] acc_reg;
    logic [23:0] acc_next;
    logic [23:0] product_reg;
    logic [15:0] status_reg;
    logic [15:0] pc_reg;
    logic nop_reg;
    logic [7:0] ptr_reg [6];
    logic [15:0] chan_read_buffer_reg [2];
    logic [15:0] chan_serial_buffer_reg [2];
    logic [15:0] chan_tx_reg [2];
    logic [1:0] chan_tx_load_reg;
    logic [15:0] serial_config_first_reg;
    logic [15:0] waitstate_config_second_reg;
    logic [15:0] timer_config_reg;
    dspreg_pkg::dspreg_cfg_slot_t cfg_slot_reg;
    logic [15:0] rd_data_reg;
    logic rd_valid_reg;
    logic [2:0] ext_addr_reg;
    logic ext_rd_reg;
    logic ext_wr_reg;
    logic [15:0] ext_dout_reg;
    logic ext_dout_oe_reg;
    logic [2:0] irq_reg;
    logic timer_on;
    logic chan_on;
    logic [7:0] ext_internal;
    logic wr_ext;
    logic rd_ext;
    logic [2:0] wr_ext_num;
    logic [2:0] rd_ext_num;
    logic [7:0] loop_mask;
    logic signed [31:0] full_product;
    logic [23:0] product_next;
    logic alu_ovf;
    logic [15:0] rd_mux;
    logic [3:0] dptr_word;

    assign timer_on = timer_config_reg[dspreg_pkg::TIMER_EN_BIT];
    assign chan_on = serial_config_first_reg[dspreg_pkg::CHAN0_EN_BIT]
        | waitstate_config_second_reg[dspreg_pkg::CHAN1_EN_BIT];

    // Map of external addresses that an enabled peripheral keeps on chip.
    always_comb begin
        ext_internal = 8'h00;
        ext_internal[dspreg_pkg::EXT_TIMER] = timer_on;
        ext_internal[dspreg_pkg::EXT_CHAN0] = chan_on;
        ext_internal[dspreg_pkg::EXT_CHAN1] = chan_on;
        ext_internal[dspreg_pkg::EXT_CONFIG] = chan_on;
    end

    assign wr_ext = wr_en_i && (wr_sel_i[4:3] == dspreg_pkg::GRP_EXT);
    assign rd_ext = rd_en_i && (rd_sel_i[4:3] == dspreg_pkg::GRP_EXT);
    assign wr_ext_num = wr_sel_i[2:0];
    assign rd_ext_num = rd_sel_i[2:0];

    // Multiplier keeps the 24 most significant bits of the 32-bit product.
    assign full_product = $signed(mpy_x_reg) * $signed(mpy_y_reg);
    always_comb begin
        product_next = full_product[31:dspreg_pkg::PROD_LSB];
        if (mpy_shift_i && status_reg[dspreg_pkg::SR_SHIFT3]) begin
            product_next = $signed(product_next) >>> dspreg_pkg::PROD_SHIFT;
        end
    end

    assign alu_ovf = alu_sum_i[24] ^ alu_sum_i[23];

    always_comb begin
        acc_next = alu_sum_i[23:0];
        if (alu_ovf && status_reg[dspreg_pkg::SR_SAT]) begin
            acc_next = alu_sum_i[24] ? dspreg_pkg::ACC_SAT_NEG : dspreg_pkg::ACC_SAT_POS;
        end
    end

    // Loop size 000 means the full 256-word ring.
    always_comb begin
        if (status_reg[dspreg_pkg::SR_LOOP_HI:dspreg_pkg::SR_LOOP_LO] == 3'h0) begin
            loop_mask = 8'hFF;
        end else begin
            loop_mask = 8'((9'h001 << status_reg[dspreg_pkg::SR_LOOP_HI:dspreg_pkg::SR_LOOP_LO])
                - 9'h001);
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mpy_x_reg <= 16'h0000;
            mpy_y_reg <= 16'h0000;
        end else if (wr_en_i && wr_sel_i == dspreg_pkg::SEL_MPY_X) begin
            mpy_x_reg <= wr_data_i;
        end else if (wr_en_i && wr_sel_i == dspreg_pkg::SEL_MPY_Y) begin
            mpy_y_reg <= wr_data_i;
        end
    end

    // The product only ever comes from the multiplier.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            product_reg <= 24'h000000;
        end else if (mpy_valid_i) begin
            product_reg <= product_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_reg <= 24'h000000;
        end else if (wr_en_i && wr_sel_i == dspreg_pkg::SEL_ACC) begin
            acc_reg <= {wr_data_i, dspreg_pkg::ACC_LOW_ZERO};
        end else if (alu_valid_i) begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_reg <= dspreg_pkg::SR_RESET;
        end else if (warm_reset_i) begin
            status_reg <= dspreg_pkg::SR_RESET;
        end else begin
            if (wr_en_i && wr_sel_i == dspreg_pkg::SEL_STATUS) begin
                status_reg[9:0] <= wr_data_i[9:0];
            end
            if (irq_entry_i) begin
                status_reg[dspreg_pkg::SR_IRQ_ALLOW] <= 1'b0;
            end
            if (alu_valid_i) begin
                status_reg[dspreg_pkg::SR_NEG] <= acc_next[23];
                status_reg[dspreg_pkg::SR_OVF] <= alu_ovf;
                status_reg[dspreg_pkg::SR_ZERO] <= (acc_next == 24'h000000);
                status_reg[dspreg_pkg::SR_CARRY] <= alu_carry_i;
            end
            status_reg[dspreg_pkg::SR_UIN1] <= user_in_one_i;
            status_reg[dspreg_pkg::SR_UIN0] <= user_in_zero_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_reg <= 16'h0000;
            nop_reg <= 1'b0;
        end else if (wr_en_i && wr_sel_i == dspreg_pkg::SEL_PC) begin
            pc_reg <= wr_data_i;
            nop_reg <= 1'b1;
        end else begin
            nop_reg <= 1'b0;
            if (pc_advance_i) begin
                pc_reg <= pc_next_i;
            end
        end
    end

    // Pointers: index is bank * 3 + number; a direct write wins over a step.
    for (genvar i = 0; i < dspreg_pkg::NUM_PTR; i++) begin : g_ptr
        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                ptr_reg[i] <= 8'h00;
            end else if (wr_en_i && wr_sel_i == 5'(dspreg_pkg::SEL_PTR_BASE + 5'(i))) begin
                ptr_reg[i] <= wr_data_i[7:0];
            end else if (ptr_step_i[i]) begin
                ptr_reg[i] <= (ptr_reg[i] & ~loop_mask)
                    | ((ptr_reg[i] + 8'h01) & loop_mask);
            end
        end
        assign ram_ptr_o[i*8 +: 8] = ptr_reg[i];
    end

    // Data pointer: short-form bits give group of four, operand gives offset.
    assign dptr_word = {status_reg[dspreg_pkg::SR_SFD_HI:dspreg_pkg::SR_SFD_LO],
        (wr_en_i && wr_sel_i[4:3] == dspreg_pkg::GRP_DPTR) ? wr_sel_i[1:0] : rd_sel_i[1:0]};
    assign dptr_addr_o = dptr_word;
    assign dptr_bank_o = (wr_en_i && wr_sel_i[4:3] == dspreg_pkg::GRP_DPTR) ? wr_sel_i[2]
        : rd_sel_i[2];
    assign dptr_wr_o = wr_en_i && (wr_sel_i[4:3] == dspreg_pkg::GRP_DPTR);
    assign dptr_wdata_o = wr_data_i;

    // Serial channels; an arriving word wins over a CPU write to the serial buffer.
    for (genvar c = 0; c < dspreg_pkg::NUM_CHAN; c++) begin : g_chan
        localparam logic [2:0] EXT_NUM_C = (c == 0) ? dspreg_pkg::EXT_CHAN0
            : dspreg_pkg::EXT_CHAN1;
        logic cpu_wr;
        assign cpu_wr = wr_ext && ext_internal[EXT_NUM_C] && wr_ext_num == EXT_NUM_C;
        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                chan_read_buffer_reg[c] <= 16'h0000;
                chan_serial_buffer_reg[c] <= 16'h0000;
                chan_tx_reg[c] <= 16'h0000;
                chan_tx_load_reg[c] <= 1'b0;
            end else begin
                chan_tx_load_reg[c] <= cpu_wr;
                if (cpu_wr) begin
                    chan_read_buffer_reg[c] <= chan_serial_buffer_reg[c];
                    chan_tx_reg[c] <= wr_data_i;
                end
                if (chan_rx_valid_i[c]) begin
                    chan_serial_buffer_reg[c] <= chan_rx_data_i[c*16 +: 16];
                end else if (cpu_wr) begin
                    chan_serial_buffer_reg[c] <= wr_data_i;
                end
            end
        end
        assign chan_tx_data_o[c*16 +: 16] = chan_tx_reg[c];
    end
    assign chan_tx_load_o = chan_tx_load_reg;

    // Configuration address alternates between the two words on each write.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_config_first_reg <= dspreg_pkg::CFG_RESET;
            waitstate_config_second_reg <= dspreg_pkg::CFG_RESET;
            cfg_slot_reg <= dspreg_pkg::DSPREG_CFG_FIRST;
        end else if (wr_ext && wr_ext_num == dspreg_pkg::EXT_CONFIG) begin
            case (cfg_slot_reg)
                dspreg_pkg::DSPREG_CFG_FIRST: begin
                    serial_config_first_reg <= wr_data_i;
                    cfg_slot_reg <= dspreg_pkg::DSPREG_CFG_SECOND;
                end
                dspreg_pkg::DSPREG_CFG_SECOND: begin
                    waitstate_config_second_reg <= wr_data_i;
                    cfg_slot_reg <= dspreg_pkg::DSPREG_CFG_FIRST;
                end
                default: begin
                    cfg_slot_reg <= dspreg_pkg::DSPREG_CFG_FIRST;
                end
            endcase
        end
    end

    // Once the timer is switched off it stays off until reset.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer_config_reg <= dspreg_pkg::TIMER_CFG_RESET;
        end else if (wr_ext && timer_on && wr_ext_num == dspreg_pkg::EXT_TIMER) begin
            timer_config_reg <= wr_data_i;
        end
    end

    // Outside bus strobes run for every external access, internal or not.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_addr_reg <= 3'h0;
            ext_rd_reg <= 1'b0;
            ext_wr_reg <= 1'b0;
            ext_dout_reg <= 16'h0000;
            ext_dout_oe_reg <= 1'b0;
        end else begin
            ext_rd_reg <= rd_ext;
            ext_wr_reg <= wr_ext;
            ext_dout_oe_reg <= wr_ext;
            if (wr_ext) begin
                ext_addr_reg <= wr_ext_num;
                ext_dout_reg <= wr_data_i;
            end else if (rd_ext) begin
                ext_addr_reg <= rd_ext_num;
            end
        end
    end

    // Read data path; an internal peripheral address ignores the pins.
    always_comb begin
        rd_mux = 16'h0000;
        case (rd_sel_i[4:3])
            2'h0: begin
                case (rd_sel_i)
                    dspreg_pkg::SEL_MPY_X: rd_mux = mpy_x_reg;
                    dspreg_pkg::SEL_MPY_Y: rd_mux = mpy_y_reg;
                    dspreg_pkg::SEL_ACC: rd_mux = acc_reg[23:8];
                    dspreg_pkg::SEL_STATUS: rd_mux = status_reg;
                    dspreg_pkg::SEL_PRODUCT: rd_mux = product_reg[23:8];
                    dspreg_pkg::SEL_PC: rd_mux = pc_reg;
                    dspreg_pkg::SEL_DBUS: rd_mux = dbus_i;
                    default: rd_mux = 16'h0000;
                endcase
            end
            2'h1: begin
                if (rd_sel_i[2:0] < 3'(dspreg_pkg::NUM_PTR)) begin
                    rd_mux = {8'h00, ptr_reg[rd_sel_i[2:0]]};
                end
            end
            dspreg_pkg::GRP_EXT: begin
                rd_mux = ext_din_i;
                if (ext_internal[rd_ext_num]) begin
                    case (rd_ext_num)
                        dspreg_pkg::EXT_TIMER: rd_mux = timer_config_reg;
                        dspreg_pkg::EXT_CHAN0: rd_mux = chan_read_buffer_reg[0];
                        dspreg_pkg::EXT_CHAN1: rd_mux = chan_read_buffer_reg[1];
                        dspreg_pkg::EXT_CONFIG: rd_mux = serial_config_first_reg;
                        default: rd_mux = ext_din_i;
                    endcase
                end
            end
            default: rd_mux = dptr_rdata_i;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en_i;
            if (rd_en_i) begin
                rd_data_reg <= rd_mux;
            end
        end
    end

    // Interrupt lines: internal events take lines one and two while enabled.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_reg <= 3'h0;
        end else begin
            irq_reg[0] <= irq_pin_i[0];
            irq_reg[1] <= chan_on ? chan_done_i : irq_pin_i[1];
            irq_reg[2] <= timer_on ? timer_zero_i : irq_pin_i[2];
        end
    end

    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign pc_o = pc_reg;
    assign nop_insert_o = nop_reg;
    assign acc_o = acc_reg;
    assign product_o = product_reg;
    assign mpy_x_o = mpy_x_reg;
    assign mpy_y_o = mpy_y_reg;
    assign status_o = status_reg;
    assign ext_addr_o = ext_addr_reg;
    assign ext_rd_o = ext_rd_reg;
    assign ext_wr_o = ext_wr_reg;
    assign ext_dout_o = ext_dout_reg;
    assign ext_dout_oe_o = ext_dout_oe_reg;
    assign ext_internal_o = ext_internal;
    assign serial_config_o = serial_config_first_reg;
    assign waitstate_config_o = waitstate_config_second_reg;
    assign timer_config_o = timer_config_reg;
    assign irq_line_general_o = irq_reg[0];
    assign irq_line_serial_o = irq_reg[1];
    assign irq_line_timer_o = irq_reg[2];
    assign irq_allow_o = status_reg[dspreg_pkg::SR_IRQ_ALLOW];
    assign user_out_zero_o = ~status_reg[dspreg_pkg::SR_UOUT0];
    assign user_out_one_o = ~status_reg[dspreg_pkg::SR_UOUT1];
endmodule // dspreg_core

`default_nettype wire

/* File: dv/dspreg_core_props.sv */
/* Assertions on the register set's top-level ports.
   Assumes a bind to dspreg_core and inputs synchronous to core_clk_i. */
`timescale 1ns/100ps
`default_nettype none
module dspreg_core_props (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic warm_reset_i,
    input wire logic wr_en_i,
    input wire logic [4:0] wr_sel_i,
    input wire logic [15:0] wr_data_i,
    input wire logic mpy_valid_i,
    input wire logic irq_entry_i,
    input wire logic [23:0] acc_o,
    input wire logic [23:0] product_o,
    input wire logic [15:0] status_o,
    input wire logic nop_insert_o,
    input wire logic ext_wr_o,
    input wire logic [2:0] ext_addr_o,
    input wire logic irq_allow_o,
    input wire logic user_out_zero_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    chk_acc_load: assert property (wr_en_i && wr_sel_i == 5'h02 |=>
        acc_o == {$past(wr_data_i), 8'h00}) else $error("acc load");
    chk_product_ro: assert property (wr_en_i && wr_sel_i == 5'h04 && !mpy_valid_i |=>
        $stable(product_o)) else $error("product written");
    chk_status_sw: assert property (wr_en_i && wr_sel_i == 5'h03 && !warm_reset_i
        && !irq_entry_i |=> status_o[9:0] == $past(wr_data_i[9:0])) else $error("status");
    chk_pc_nop: assert property (wr_en_i && wr_sel_i == 5'h05 |=> nop_insert_o)
        else $error("no nop");
    chk_irq_clear: assert property (irq_entry_i |=> !irq_allow_o)
        else $error("allow kept");
    chk_warm_clear: assert property (warm_reset_i |=> status_o[9:0] == 10'h000)
        else $error("warm");
    chk_uout_inv: assert property (user_out_zero_o == !status_o[5])
        else $error("user out");
    chk_ext_strobe: assert property (wr_en_i && wr_sel_i[4:3] == 2'h2 |=>
        ext_wr_o && ext_addr_o == $past(wr_sel_i[2:0])) else $error("ext strobe");
endmodule // dspreg_core_props
`default_nettype wire

/* File: dv/dspreg_ext_model.sv */
/* Far-side latches for the eight external register addresses.
   Assumes the core's strobes, address and data are registered on core_clk_i. */
`timescale 1ns/100ps
`default_nettype none
module dspreg_ext_model (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ext_wr_o,
    input wire logic [2:0] ext_addr_o,
    input wire logic [15:0] ext_dout_o,
    input wire logic [7:0] ext_internal_o,
    output logic [15:0] bus_din_o
);
    logic [15:0] mem [8];
    logic hit;
    assign hit = ext_internal_o[ext_addr_o];
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) mem <= '{default: 16'h0000};
        else if (ext_wr_o && !hit) mem[ext_addr_o] <= ext_dout_o;
    end
    // An address held on chip is not driven from outside, so it shows a changed word.
    assign bus_din_o = hit ? ~mem[ext_addr_o] : mem[ext_addr_o];
endmodule // dspreg_ext_model
`default_nettype wire

/* File: dv/tb.sv */
/* Self-checking bench for the register set with the far-side bus model.
   Assumes the package, the core, the model and the checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic core_clk_i, rstn_i = 0, warm_reset_i = 0, rd_en_i = 0, wr_en_i = 0, alu_valid_i = 0;
    logic alu_carry_i = 0, mpy_valid_i = 0, mpy_shift_i = 0, pc_advance_i = 0, chan_done_i = 0;
    logic timer_zero_i = 0, irq_entry_i = 0, user_in_zero_i = 0, user_in_one_i = 0;
    logic rd_valid_o, nop_insert_o, dptr_bank_o, dptr_wr_o, ext_rd_o, ext_wr_o, ext_dout_oe_o;
    logic irq_line_general_o, irq_line_serial_o, irq_line_timer_o, irq_allow_o;
    logic user_out_zero_o, user_out_one_o;
    logic [1:0] chan_rx_valid_i = 0, chan_tx_load_o;
    logic [2:0] irq_pin_i = 0, ext_addr_o;
    logic [3:0] dptr_addr_o;
    logic [4:0] rd_sel_i = 0, wr_sel_i = 0;
    logic [5:0] ptr_step_i = 0;
    logic [7:0] ext_internal_o;
    logic [15:0] wr_data_i = 0, dbus_i = 0, pc_next_i = 0, dptr_rdata_i = 0, ext_din_i;
    logic [15:0] rd_data_o, pc_o, mpy_x_o, mpy_y_o, status_o, dptr_wdata_o, ext_dout_o;
    logic [15:0] serial_config_o, waitstate_config_o, timer_config_o;
    logic [23:0] acc_o, product_o;
    logic [24:0] alu_sum_i = 0;
    logic [31:0] chan_rx_data_i = 0, chan_tx_data_o;
    logic [47:0] ram_ptr_o;
    int n_mismatch = 0, checked = 0;
    dspreg_core dspreg_core_inst (.*);
    dspreg_ext_model dspreg_ext_model_inst (.*, .bus_din_o(ext_din_i));
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [4:0] sel, logic [15:0] d);
        @(posedge core_clk_i) #1 {wr_en_i, wr_sel_i, wr_data_i} = {1'b1, sel, d};
        @(posedge core_clk_i) #1 wr_en_i = 0;
    endtask
    task automatic rd(logic [4:0] sel, logic [15:0] exp, string what);
        @(posedge core_clk_i) #1 {rd_en_i, rd_sel_i} = {1'b1, sel};
        @(posedge core_clk_i) #1 rd_en_i = 0;
        chk(what, {rd_valid_o, rd_data_o}, {1'b1, exp});
    endtask
    task automatic pulse(ref logic s);
        @(posedge core_clk_i) #1 s = 1;
        @(posedge core_clk_i) #1 s = 0;
    endtask
    task automatic t_regs;
        chk("reset", {status_o, 7'h00, user_out_zero_o, ext_internal_o}, 32'h00000110);
        wr(5'h02, 16'h1234);
        chk("acc", acc_o, 24'h123400);
        rd(5'h02, 16'h1234, "acc rd");
        wr(5'h04, 16'hBEEF);
        rd(5'h04, 16'h0000, "product");
        for (int i = 0; i < 6; i++) wr(5'h08 + 5'(i), 16'(8'hA0 + i));
        for (int i = 0; i < 6; i++) rd(5'h08 + 5'(i), 16'(8'hA0 + i), "ptr");
        dbus_i = 16'h5A5A;
        rd(5'h06, 16'h5A5A, "dbus");
        wr(5'h05, 16'h0042);
        chk("nop", {nop_insert_o, pc_o}, {1'b1, 16'h0042});
    endtask
    task automatic t_status;
        {user_in_zero_i, user_in_one_i} = 2'b11;
        wr(5'h03, 16'hFFFF);
        chk("status", status_o, 16'h0FFF);
        chk("uout", {user_out_one_o, user_out_zero_o}, 2'b00);
        alu_sum_i = 25'h0800000;
        pulse(alu_valid_i);
        chk("sat", {acc_o, status_o[15:12]}, {24'h7FFFFF, 4'h4});
        pulse(irq_entry_i);
        chk("allow", irq_allow_o, 1'b0);
        pulse(warm_reset_i);
        chk("warm", status_o[9:0], 10'h000);
    endtask
    task automatic t_ext;
        wr(5'h11, 16'h0005);
        @(posedge core_clk_i) #1;
        chk("ext wr", dspreg_ext_model_inst.mem[1], 16'h0005);
        rd(5'h11, 16'h0005, "ext rd");
        wr(5'h14, 16'h8123);
        @(posedge core_clk_i) #1;
        chk("ext timer", dspreg_ext_model_inst.mem[4], 16'h0000);
        wr(5'h17, 16'h8000);
        wr(5'h17, 16'h0321);
        chk("cfg", {serial_config_o, waitstate_config_o}, 32'h80000321);
        rd(5'h17, 16'h8000, "cfg rd");
        chk("ext map", ext_internal_o, 8'hF0);
        wr(5'h14, 16'h0000);
        wr(5'h14, 16'h1234);
        @(posedge core_clk_i) #1;
        chk("ext free", {timer_config_o, dspreg_ext_model_inst.mem[4]}, 32'h00001234);
    endtask
    task automatic t_chan;
        @(posedge core_clk_i) #1 {chan_rx_valid_i, chan_rx_data_i} = {2'b01, 32'h0000C0DE};
        @(posedge core_clk_i) #1 chan_rx_valid_i = 0;
        wr(5'h15, 16'h7E57);
        chk("tx", {chan_tx_load_o, chan_tx_data_o[15:0]}, {2'b01, 16'h7E57});
        rd(5'h15, 16'hC0DE, "rx");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        core_clk_i = 0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    initial begin
        #100000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge core_clk_i);
        #1 rstn_i = 1;
        t_regs;
        t_status;
        t_ext;
        t_chan;
        wrap_up;
    end
endmodule // tb
bind dspreg_core dspreg_core_props dspreg_core_props_inst (.*);
`default_nettype wire
